// ===== rtl/i2cs_defines.svh
// Constants shared by both ends of the two-wire register access port
`ifndef I2CS_DEFINES_SVH
`define I2CS_DEFINES_SVH
// Upper six bits of the slave address; the low bit comes from the select pin
`define I2CS_ADDR_HI 6'h0E
// Register array size and value read back from reserved locations
`define I2CS_REG_NUM 64
`define I2CS_RSVD_VAL 8'h00
// Write report FIFO shape: {index, data}
`define I2CS_FIFO_W 16
`define I2CS_FIFO_DEPTH 16
// Host clock and bus rates in Hz
`define I2CS_SYS_HZ 50000000
`define I2CS_FM_HZ 400000
`define I2CS_SM_HZ 100000
// Quarter bus period in host cycles, rounded up
`define I2CS_QTR_FM ((`I2CS_SYS_HZ + 4 * `I2CS_FM_HZ - 1) / (4 * `I2CS_FM_HZ))
`define I2CS_QTR_SM ((`I2CS_SYS_HZ + 4 * `I2CS_SM_HZ - 1) / (4 * `I2CS_SM_HZ))
`endif

// ===== rtl/i2cs_pkg.sv
// Types shared by both ends of the two-wire register access port
package i2cs_pkg;
    // Device end protocol states
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK, ST_IGNORE
    } i2cs_sst_t;
    // Host end bus element states
    typedef enum logic [1:0] {M_IDLE, M_START, M_STOP, M_BIT} i2cs_mst_t;
    // Host command codes
    typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ} i2cs_cmd_t;
endpackage : i2cs_pkg

// ===== rtl/i2cs_if.sv
// Open-drain two-wire bus joining host and device ends
interface i2cs_if;
    logic m_scl_o;
    logic m_scl_oe_n;
    logic m_sda_o;
    logic m_sda_oe_n;
    logic s_sda_o;
    logic s_sda_oe_n;
    logic scl;
    logic sda;
    // Wired-AND with pull-ups: a line is low only when some driver pulls it
    assign scl = ~(~m_scl_oe_n & ~m_scl_o);
    assign sda = ~((~m_sda_oe_n & ~m_sda_o) | (~s_sda_oe_n & ~s_sda_o));
    modport master (output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n, input scl, sda);
    modport slave (output s_sda_o, s_sda_oe_n, input scl, sda);
endinterface : i2cs_if

// ===== rtl/i2cs_fifo.sv
// Synchronous FIFO with valid/ready on both sides
module i2cs_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    // Full, empty and transfer decode
    assign in_ready_o = cnt_ff != (AW+1)'(DEPTH);
    assign out_valid_o = cnt_ff != '0;
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign out_data_o = mem_ff[rp_ff];

    // Pointers wrap naturally; depth must be a power of two
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff <= wp_ff + AW'(push);
            rp_ff <= rp_ff + AW'(pop);
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_ff[wp_ff] <= in_data_i;
        end
    end
endmodule : i2cs_fifo

// ===== rtl/i2cs_slave.sv
// Device end: two-wire slave with register array and write report stream
// Operation
// - Off mode: ignore bus, never drive data
// - Works at standard and fast bus rates
// - Lines idle high; only pulled low
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - First byte: seven address bits, direction
// - Selected only when address bits match
// - Receiver holds data low in ninth clock
// - Address low bit follows select pin
// - Repeated start accepted mid transfer
// - Index byte acknowledged, loaded into pointer
// - Read address acknowledged, register shifted out
// - Data MSB first, changed after falling clock
// - Host ends read with NAK, stop
// - Read pointer advances; continues while acknowledged
// - Data bytes acknowledged and stored at index while the write report FIFO has room, else refused
// - Write pointer advances per stored byte
// - Reserved locations read as zero
`include "i2cs_defines.svh"
module i2cs_slave
    import i2cs_pkg::*;
(
    input wire logic link_clk_i,
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic core_on_i,
    input wire logic addr_select_pin_i,
    i2cs_if.slave bus,
    output logic wr_valid_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    input wire logic wr_ready_i
);
    logic lrst_a_ff, lrst_b_ff, lrst_n;
    logic [3:0] in_a_ff, in_b_ff;
    logic scl_d_ff, sda_d_ff, scl_s, sda_s, sel_s, core_s;
    logic start_det, stop_det, scl_rise, scl_fall;
    i2cs_sst_t st_ff, nxt_st, ack_nxt_ff, nxt_ack;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] sh_ff, nxt_sh, ptr_ff, nxt_ptr, rd_byte, ptr_inc;
    logic sda_low_ff, nxt_low, acked_ff, nxt_acked;
    logic do_wr, wr_room, addr_hit, rsvd, f_valid, x_idle;
    logic [7:0] regs_ff [`I2CS_REG_NUM];
    logic [15:0] f_data, hold_ff, wr_word_ff;
    logic req_ff, ack_a_ff, ack_b_ff, req_a_ff, req_b_ff, ack_ff, wr_valid_ff;
    // ------------------------------------------------------------
    // Link domain reset and input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge link_clk_i) begin
        {lrst_b_ff, lrst_a_ff} <= {lrst_a_ff, rst_n_i};
    end
    assign lrst_n = lrst_b_ff;
    // Bus lines, select pin and core supply state pass two flops
    always_ff @(posedge link_clk_i) begin
        if (!lrst_n) begin
            in_a_ff <= 4'hC;
            in_b_ff <= 4'hC;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            in_a_ff <= {bus.scl, bus.sda, addr_select_pin_i, core_on_i};
            in_b_ff <= in_a_ff;
            scl_d_ff <= in_b_ff[3];
            sda_d_ff <= in_b_ff[2];
        end
    end
    // Bus event decode from the synchronised levels
    assign {scl_s, sda_s, sel_s, core_s} = in_b_ff;
    assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    assign stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    assign scl_rise = scl_s & ~scl_d_ff;
    assign scl_fall = ~scl_s & scl_d_ff;
    assign addr_hit = sh_ff[7:1] == {`I2CS_ADDR_HI, sel_s};
    assign rsvd = ptr_ff[7:6] != 2'b00;
    assign rd_byte = rsvd ? `I2CS_RSVD_VAL : regs_ff[ptr_ff[5:0]];
    assign ptr_inc = ptr_ff + 8'h01;
    // ------------------------------------------------------------
    // Protocol state machine
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_ack = ack_nxt_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_ptr = ptr_ff;
        nxt_low = sda_low_ff;
        nxt_acked = acked_ff;
        do_wr = 1'b0;
        // off mode or stop releases line
        if (!core_s || stop_det) begin
            nxt_st = ST_IDLE;
            nxt_low = 1'b0;
        end else if (start_det) begin
            nxt_st = ST_ADDR;
            nxt_cnt = 4'h0;
            nxt_low = 1'b0;
        end else begin
            unique case (st_ff)
                ST_IDLE, ST_IGNORE: begin
                end
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (scl_rise) begin
                        nxt_sh = {sh_ff[6:0], sda_s};
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (scl_fall && cnt_ff == 4'h8) begin
                        nxt_st = ST_ACK;
                        nxt_low = 1'b1;
                        if (st_ff == ST_ADDR) begin
                            nxt_ack = sh_ff[0] ? ST_RDATA : ST_REG;
                            if (!addr_hit) begin
                                nxt_st = ST_IGNORE;
                                nxt_low = 1'b0;
                            end
                        end else if (st_ff == ST_REG) begin
                            nxt_ptr = sh_ff;
                            nxt_ack = ST_WDATA;
                        end else if (wr_room) begin
                            do_wr = 1'b1;
                            nxt_ptr = ptr_inc;
                            nxt_ack = ST_WDATA;
                        end else begin
                            nxt_low = 1'b0;
                            nxt_ack = ST_IGNORE;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        nxt_low = 1'b0;
                        nxt_cnt = 4'h0;
                        nxt_st = ack_nxt_ff;
                        if (ack_nxt_ff == ST_RDATA) begin
                            nxt_sh = rd_byte;
                            nxt_ptr = ptr_inc;
                            nxt_low = ~rd_byte[7];
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_ff == 4'h7) begin
                            nxt_low = 1'b0;
                            nxt_st = ST_RACK;
                        end else begin
                            nxt_sh = {sh_ff[6:0], 1'b0};
                            nxt_low = ~sh_ff[6];
                            nxt_cnt = cnt_ff + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        nxt_acked = ~sda_s;
                    end else if (scl_fall) begin
                        nxt_cnt = 4'h0;
                        if (acked_ff) begin
                            nxt_st = ST_RDATA;
                            nxt_sh = rd_byte;
                            nxt_ptr = ptr_inc;
                            nxt_low = ~rd_byte[7];
                        end else begin
                            nxt_st = ST_IGNORE;
                        end
                    end
                end
            endcase
        end
    end
    // State registers
    always_ff @(posedge link_clk_i) begin
        if (!lrst_n) begin
            st_ff <= ST_IDLE;
            ack_nxt_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            ptr_ff <= 8'h00;
            sda_low_ff <= 1'b0;
            acked_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            ack_nxt_ff <= nxt_ack;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            ptr_ff <= nxt_ptr;
            sda_low_ff <= nxt_low;
            acked_ff <= nxt_acked;
        end
    end
    assign bus.s_sda_o = 1'b0;
    assign bus.s_sda_oe_n = ~sda_low_ff;
    // Register array, writes to reserved space dropped
    for (genvar i = 0; i < `I2CS_REG_NUM; i++) begin : g_reg
        always_ff @(posedge link_clk_i) begin
            if (!lrst_n) begin
                regs_ff[i] <= 8'h00;
            end else if (do_wr && !rsvd && ptr_ff[5:0] == 6'(i)) begin
                regs_ff[i] <= sh_ff;
            end
        end
    end

    // ------------------------------------------------------------
    // Write report path: FIFO, then handshake into host clock
    // ------------------------------------------------------------
    i2cs_fifo #(.W(`I2CS_FIFO_W), .DEPTH(`I2CS_FIFO_DEPTH)) u_fifo (
        .clk_i(link_clk_i),
        .rst_n_i(lrst_n),
        .in_valid_i(do_wr),
        .in_ready_o(wr_room),
        .in_data_i({ptr_ff, sh_ff}),
        .out_valid_o(f_valid),
        .out_ready_i(x_idle),
        .out_data_o(f_data)
    );
    // Link side: one word in flight, toggle request
    assign x_idle = req_ff == ack_b_ff;
    always_ff @(posedge link_clk_i) begin
        if (!lrst_n) begin
            req_ff <= 1'b0;
            hold_ff <= 16'h0000;
            ack_a_ff <= 1'b0;
            ack_b_ff <= 1'b0;
        end else begin
            ack_a_ff <= ack_ff;
            ack_b_ff <= ack_a_ff;
            if (f_valid && x_idle) begin
                req_ff <= ~req_ff;
                hold_ff <= f_data;
            end
        end
    end
    // Host clock side: present word, toggle acknowledge on take
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            req_a_ff <= 1'b0;
            req_b_ff <= 1'b0;
            ack_ff <= 1'b0;
            wr_valid_ff <= 1'b0;
            wr_word_ff <= 16'h0000;
        end else begin
            req_a_ff <= req_ff;
            req_b_ff <= req_a_ff;
            if (wr_valid_ff && wr_ready_i) begin
                wr_valid_ff <= 1'b0;
                ack_ff <= ~ack_ff;
            end else if (!wr_valid_ff && req_b_ff != ack_ff) begin
                wr_valid_ff <= 1'b1;
                wr_word_ff <= hold_ff;
            end
        end
    end
    assign wr_valid_o = wr_valid_ff;
    assign {wr_addr_o, wr_data_o} = wr_word_ff;
endmodule : i2cs_slave

// ===== rtl/i2cs_master.sv
// Host end: byte-level two-wire bus master with command/response port
`include "i2cs_defines.svh"
module i2cs_master
    import i2cs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic fast_mode_i,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire i2cs_cmd_t cmd_i,
    input wire logic [7:0] cmd_data_i,
    input wire logic cmd_nak_i,
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    output logic rsp_nak_o,
    i2cs_if.master bus
);
    localparam logic [7:0] QTR_FM = 8'(`I2CS_QTR_FM);
    localparam logic [7:0] QTR_SM = 8'(`I2CS_QTR_SM);
    i2cs_mst_t st_ff;
    i2cs_mst_t cmd_st;
    logic [1:0] q_ff;
    logic [7:0] qc_ff;
    logic [3:0] bi_ff;
    logic [8:0] tx_ff;
    logic [8:0] rx_ff;
    logic [8:0] cmd_tx;
    logic scl_low_ff;
    logic sda_low_ff;
    logic nxt_scl_low;
    logic nxt_sda_low;
    logic sda_a_ff;
    logic sda_b_ff;
    logic rsp_valid_ff;
    logic [7:0] rsp_data_ff;
    logic rsp_nak_ff;
    logic [7:0] qlim;
    logic tick;
    logic end_step;
    logic fin;
    logic accept;
    logic edge_q;

    // ------------------------------------------------------------
    // Timing and command decode
    // ------------------------------------------------------------
    // quarter period per bus mode
    assign qlim = fast_mode_i ? QTR_FM : QTR_SM;
    assign tick = qc_ff == qlim - 8'h01;
    assign end_step = tick & (q_ff == 2'h3);
    assign fin = end_step & ((st_ff != M_BIT) | (bi_ff == 4'h8));
    assign cmd_ready_o = st_ff == M_IDLE;
    assign accept = cmd_valid_i & cmd_ready_o;
    assign edge_q = q_ff[0] ~^ q_ff[1];
    assign cmd_st = (cmd_i == CMD_START) ? M_START : (cmd_i == CMD_STOP) ? M_STOP : M_BIT;
    // read ends with host ACK or NAK bit taken from cmd_nak_i
    assign cmd_tx = (cmd_i == CMD_WRITE) ? {cmd_data_i, 1'b1} : {8'hFF, cmd_nak_i};

    // Line levels per element and quarter
    always_comb begin
        nxt_scl_low = scl_low_ff;
        nxt_sda_low = sda_low_ff;
        unique case (st_ff)
            M_IDLE: begin
            end
            M_START: begin
                nxt_scl_low = edge_q;
                nxt_sda_low = q_ff[1];
            end
            M_STOP: begin
                nxt_scl_low = q_ff == 2'h0;
                nxt_sda_low = ~q_ff[1];
            end
            M_BIT: begin
                nxt_scl_low = edge_q;
                nxt_sda_low = ~tx_ff[8];
            end
        endcase
    end

    // Data line synchroniser
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sda_a_ff <= 1'b1;
            sda_b_ff <= 1'b1;
        end else begin
            sda_a_ff <= bus.sda;
            sda_b_ff <= sda_a_ff;
        end
    end

    // ------------------------------------------------------------
    // Element sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_ff <= M_IDLE;
            q_ff <= 2'h0;
            qc_ff <= 8'h00;
            bi_ff <= 4'h0;
            tx_ff <= 9'h1FF;
            rx_ff <= 9'h000;
            scl_low_ff <= 1'b0;
            sda_low_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= 8'h00;
            rsp_nak_ff <= 1'b0;
        end else begin
            scl_low_ff <= nxt_scl_low;
            sda_low_ff <= nxt_sda_low;
            rsp_valid_ff <= fin;
            if (accept) begin
                st_ff <= cmd_st;
                q_ff <= 2'h0;
                qc_ff <= 8'h00;
                bi_ff <= 4'h0;
                tx_ff <= cmd_tx;
            end else if (st_ff != M_IDLE) begin
                qc_ff <= tick ? 8'h00 : qc_ff + 8'h01;
                q_ff <= q_ff + 2'(tick);
                if (tick && q_ff == 2'h2 && st_ff == M_BIT) begin
                    rx_ff <= {rx_ff[7:0], sda_b_ff};
                end
                if (end_step) begin
                    bi_ff <= bi_ff + 4'h1;
                    tx_ff <= {tx_ff[7:0], 1'b1};
                end
                if (fin) begin
                    st_ff <= M_IDLE;
                    rsp_data_ff <= rx_ff[8:1];
                    rsp_nak_ff <= rx_ff[0];
                end
            end
        end
    end

    assign bus.m_scl_o = 1'b0;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_scl_oe_n = ~scl_low_ff;
    assign bus.m_sda_oe_n = ~sda_low_ff;
    assign rsp_valid_o = rsp_valid_ff;
    assign rsp_data_o = rsp_data_ff;
    assign rsp_nak_o = rsp_nak_ff;
endmodule : i2cs_master

// ===== test/i2cs_props.sv
// Wire-level checks on the bus joining host end and device end
module i2cs_props (
    input wire logic sys_clk_i,
    input wire logic link_clk_i,
    input wire logic rst_n_i,
    input wire logic core_on_i,
    input wire logic m_scl_o,
    input wire logic m_scl_oe_n,
    input wire logic m_sda_o,
    input wire logic m_sda_oe_n,
    input wire logic s_sda_o,
    input wire logic s_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Host clock domain
    // ----------------------------------------
    // Bus conditions seen on the resolved wires
    sequence s_start;
        $fell(sda) && scl && $past(scl);
    endsequence
    sequence s_stop;
        $rose(sda) && scl && $past(scl);
    endsequence
    chk_host_pull_only: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (m_scl_oe_n | ~m_scl_o) & (m_sda_oe_n | ~m_sda_o)) else $error("host drives a line high");
    chk_start_by_host: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_start |-> !m_sda_oe_n) else $error("data fell under high clock without host");
    chk_stop_released: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_stop |-> $past(s_sda_oe_n) && !$past(m_sda_oe_n)) else $error("stop not made by host alone");
    chk_scl_high_time: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(scl) |-> scl [*8]) else $error("clock high phase too short");
    chk_ack_steady: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        scl && $past(scl) && !$past(s_sda_oe_n) |-> !s_sda_oe_n) else $error("device let go in high phase");
    // ----------------------------------------
    // Device clock domain
    // ----------------------------------------
    chk_dev_pull_only: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        !s_sda_oe_n |-> !s_sda_o) else $error("device drives data high");
    chk_off_quiet: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        !core_on_i [*6] |-> s_sda_oe_n) else $error("device drives data while off");
    chk_edge_on_low: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        $changed(s_sda_oe_n) && $past(core_on_i, 4) |-> !scl) else $error("device data moved under high clock");
    chk_ack_release: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
        $fell(s_sda_oe_n) |-> ##[1:1000] s_sda_oe_n) else $error("device never releases data");
endmodule : i2cs_props

// ===== test/i2c_register_access_slave_test.sv
// Bench: host end drives the device end across the two-wire bus
module i2c_register_access_slave_test import i2cs_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk_i = 1'b0, link_clk_i = 1'b0, rst_n_i = 1'b0, core_on = 1'b1, pin = 1'b1, fast = 1'b1;
    logic stall = 1'b0, wr_ready = 1'b0, cmd_valid = 1'b0, cmd_nak = 1'b0;
    logic [7:0] cmd_data = 8'h00;
    i2cs_cmd_t cmd = CMD_START;
    logic cmd_ready, rsp_valid, rsp_nak, wr_valid;
    logic [7:0] rsp_data, wr_addr, wr_data;
    logic [9:0] e;
    logic [9:0] rsp_q[$];
    logic [15:0] wr_q[$];
    int error_cnt = 0;
    int total_checks = 0;
    i2cs_if bus ();
    // Both ends and the wire checker
    i2cs_master i_i2cs_master (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .fast_mode_i(fast), .cmd_valid_i(cmd_valid),
        .cmd_ready_o(cmd_ready), .cmd_i(cmd), .cmd_data_i(cmd_data), .cmd_nak_i(cmd_nak), .rsp_valid_o(rsp_valid),
        .rsp_data_o(rsp_data), .rsp_nak_o(rsp_nak), .bus(bus.master));
    i2cs_slave i_i2cs_slave (.link_clk_i(link_clk_i), .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .core_on_i(core_on),
        .addr_select_pin_i(pin), .bus(bus.slave), .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
        .wr_ready_i(wr_ready));
    i2cs_props i_i2cs_props (.sys_clk_i(sys_clk_i), .link_clk_i(link_clk_i), .rst_n_i(rst_n_i), .core_on_i(core_on),
        .m_scl_o(bus.m_scl_o), .m_scl_oe_n(bus.m_scl_oe_n), .m_sda_o(bus.m_sda_o), .m_sda_oe_n(bus.m_sda_oe_n),
        .s_sda_o(bus.s_sda_o), .s_sda_oe_n(bus.s_sda_oe_n), .scl(bus.scl), .sda(bus.sda));
    // Host clock and unrelated device clock
    always #10 sys_clk_i = ~sys_clk_i;
    always #62.5 link_clk_i = ~link_clk_i;
    // Random consumer stalls on the write report port
    always @(posedge sys_clk_i) wr_ready <= !stall && ($urandom_range(1) == 1);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    // One host command, held until taken; expectation noted
    task automatic op(input i2cs_cmd_t c, input logic [7:0] d, input logic n, input logic [9:0] exp);
        int k;
        @(posedge sys_clk_i);
        cmd_valid <= 1'b1;
        cmd <= c;
        cmd_data <= d;
        cmd_nak <= n;
        rsp_q.push_back(exp);
        k = 0;
        do begin
            @(negedge sys_clk_i);
            k++;
        end while (cmd_ready !== 1'b1 && k < 6000);
        if (k >= 6000) begin
            error_cnt++;
            stop_test();
        end
        @(posedge sys_clk_i);
        cmd_valid <= 1'b0;
    endtask : op
    // Bus element shorthands
    task automatic st();
        op(CMD_START, 8'h00, 1'b0, 10'h000);
    endtask : st
    task automatic sp();
        op(CMD_STOP, 8'h00, 1'b0, 10'h000);
    endtask : sp
    task automatic wr(input logic [7:0] d, input logic n);
        op(CMD_WRITE, d, 1'b0, {1'b1, d, n});
    endtask : wr
    task automatic rd(input logic [7:0] d, input logic n);
        op(CMD_READ, 8'h00, n, {1'b1, d, n});
    endtask : rd
    task automatic wd(input logic [7:0] idx, input logic [7:0] d);
        wr_q.push_back({idx, d});
        wr(d, 1'b0);
    endtask : wd
    task automatic hdr(input logic [7:0] a, input logic [7:0] idx);
        st();
        wr(a, 1'b0);
        wr(idx, 1'b0);
    endtask : hdr
    // Wait until every noted result has been seen
    task automatic drain();
        int k;
        k = 0;
        while ((rsp_q.size() > 0 || wr_q.size() > 0) && k < 9000) begin
            @(posedge sys_clk_i);
            k++;
        end
        if (k >= 9000) begin
            error_cnt++;
            stop_test();
        end
    endtask : drain
    // Pair each response and write report with the oldest note
    always @(negedge sys_clk_i) begin
        if (rsp_valid === 1'b1) begin
            e = (rsp_q.size() > 0) ? rsp_q.pop_front() : 10'h2AA;
            if (e[9]) begin
                check({7'h00, rsp_data, rsp_nak}, {7'h00, e[8:0]});
            end
        end
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            check({wr_addr, wr_data}, (wr_q.size() > 0) ? wr_q.pop_front() : 16'hXXXX);
        end
    end
    // Reset, then the scenarios in turn
    initial begin
        logic [7:0] r;
        void'($urandom(93905));
        repeat (10) @(posedge sys_clk_i);
        repeat (4) @(posedge link_clk_i);
        @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (8) @(posedge link_clk_i);
        // burst write running into reserved space
        hdr(8'h3A, 8'h3E);
        wd(8'h3E, 8'hA5);
        wd(8'h3F, 8'h5A);
        wd(8'h40, 8'hC3);
        sp();
        // repeated start, burst read, reserved reads zero
        hdr(8'h3A, 8'h3E);
        st();
        wr(8'h3B, 1'b0);
        rd(8'hA5, 1'b0);
        rd(8'h5A, 1'b0);
        rd(8'h00, 1'b1);
        sp();
        drain();
        fast <= 1'b0;
        hdr(8'h3A, 8'h3F);
        st();
        wr(8'h3B, 1'b0);
        rd(8'h5A, 1'b1);
        sp();
        drain();
        fast <= 1'b1;
        // both select levels, other address ignored
        for (int p = 0; p < 2; p++) begin
            pin <= p[0];
            repeat (8) @(posedge link_clk_i);
            r = 8'($urandom);
            st();
            wr({6'h0E, ~p[0], 1'b0}, 1'b1);
            hdr({6'h0E, p[0], 1'b0}, 8'h20);
            wd(8'h20, r);
            sp();
            drain();
        end
        // off mode leaves the bus alone
        core_on <= 1'b0;
        repeat (8) @(posedge link_clk_i);
        st();
        wr(8'h3A, 1'b1);
        sp();
        drain();
        core_on <= 1'b1;
        stall <= 1'b1;
        repeat (8) @(posedge link_clk_i);
        // reports pile up until the next byte is refused
        hdr(8'h3A, 8'h00);
        for (int i = 0; i < 17; i++) begin
            wd(8'(i), 8'(i + 7));
        end
        wr(8'hEE, 1'b1);
        sp();
        stall <= 1'b0;
        drain();
        stop_test();
    end
endmodule : i2c_register_access_slave_test
